// ==== common/wmcr_pkg.sv ====
// Function
// - Control bit 4 enables frame check of received frames; keep it set.
// - Control bit 5 high starts an exchange; software toggles it after scheduled wake.
// - Control bit 6 freezes the chip until the resume pin is asserted.
// - Sleep register: duration in bits 5:0, unit in 7:6 (s, min, h, day).
// - Sel_a codes 0..3 give 0.5, 1, 2, 4 ms in the enable timer.
// - Transmit, receive, turnaround codes 0..3 give 0.125, 0.25, 0.5, 1 ms.
// - Channel dwell codes 0..3 give 5, 10, 20, 40 ms.
// - Failed transaction retried 2, 8, 16 or 63 times, then link error.
// - Peer not found on wake: fallback sleep of 4, 8, 16 or 32 s.
// - Bypass bit 0 set: bits 1..4 drive the four radio enables directly.
// - Payload word limit 24..2560 from 3-bit code; same across the network.
// - Wait-cycle limit in bits 1:0, search retry count in bits 3:2.
// - Strength bypass set: 4-bit channel override indexes the channel table.
// - Link bit 5 enables drift correction, bit 6 enables bitstream capture.
// - Memory split code: 00/11 32/32kB, 01 16/48kB, 10 48/16kB.
// - Preamble length 40, 80, 120 or 160 bits by 2-bit code.
// - Frame-control enable and mode lengths 0, 10, 20 symbols, code 3 unlimited.
// - Ready retime delay 0/10/20/40, update period 10/20/40/80 symbols.
// - Ready active length 1, 2, 4 update periods, code 3 unlimited.
// - Memory word count 14 bits over two registers; bytes = words * 11 / 8.
// - Tuning bit 0 disables talk-check, bit 2 transfer timeout, bit 1 auto address.
// - Tuning bit 3 busy timeout link error, bit 6 freeze, bit 4 no parity check.
// - Tuning bit 7 clear: sleep 512/256 ms after wake; bit 5 uses fallback time.
// - Control bit 3 enables the controller; low holds its key signals reset.
package wmcr_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned SYNTH_BASE_US = 500;
  localparam int unsigned SETTLE_BASE_US = 125;
  localparam int unsigned DWELL_BASE_MS = 5;
  localparam int unsigned SYNTH_BASE_CYC = SYNTH_BASE_US * CLK_MHZ;
  localparam int unsigned SETTLE_BASE_CYC = SETTLE_BASE_US * CLK_MHZ;
  localparam int unsigned DWELL_BASE_CYC = DWELL_BASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 21;
  localparam logic [9:0] WAKE_TO_BASE_MS = 10'h200;
  localparam logic [9:0] WAKE_TO_TARGET_MS = 10'h100;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_CTRL = 8'hD4;
  localparam logic [7:0] IDX_SLEEP = 8'hD5;
  localparam logic [7:0] IDX_RADIO = 8'hD6;
  localparam logic [7:0] IDX_DWELL = 8'hDC;
  localparam logic [7:0] IDX_BYPASS = 8'hDD;
  localparam logic [7:0] IDX_SEARCH = 8'hDE;
  localparam logic [7:0] IDX_CHAN = 8'hDF;
  localparam logic [7:0] IDX_PRE = 8'hEC;
  localparam logic [7:0] IDX_READY = 8'hED;
  localparam logic [7:0] IDX_MWL = 8'hEE;
  localparam logic [7:0] IDX_MWH = 8'hEF;
  localparam logic [7:0] IDX_TUNE = 8'hF1;
  localparam int unsigned NUM_REGS = 12;
  localparam logic [7:0] REG_RST = 8'h00;

  // writable bits per register; the rest is reserved
  localparam logic [7:0] MASK_CTRL = 8'h78;
  localparam logic [7:0] MASK_DWELL = 8'hFC;
  localparam logic [7:0] MASK_CHAN = 8'h3F;
  localparam logic [7:0] MASK_READY = 8'h0F;
  localparam logic [7:0] MASK_MWH = 8'h3F;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CTRL_ON_BIT = 3;
  localparam int unsigned CTRL_CRC_BIT = 4;
  localparam int unsigned CTRL_START_BIT = 5;
  localparam int unsigned CTRL_HIB_BIT = 6;
  localparam int unsigned TWO_BIT_LSB0 = 0;
  localparam int unsigned TWO_BIT_LSB1 = 2;
  localparam int unsigned TWO_BIT_LSB2 = 4;
  localparam int unsigned TWO_BIT_LSB3 = 6;
  localparam int unsigned PAYLOAD_LSB = 5;
  localparam int unsigned SEARCH_STRENGTH_BIT = 4;
  localparam int unsigned SEARCH_DRIFT_BIT = 5;
  localparam int unsigned SEARCH_STREAM_BIT = 6;

  // ****************************************
  // decoded configuration carried to the controller
  // ****************************************
  typedef struct packed {
    logic frame_check_enable;
    logic begin_exchange;
    logic controller_on;
    logic [5:0] sleep_value;
    logic [1:0] sleep_unit;
    logic [CNT_W-1:0] channel_wait_cyc;
    logic [5:0] transaction_retry_limit;
    logic [5:0] fallback_s;
    logic controller_bypass;
    logic [11:0] payload_word_limit;
    logic [1:0] wait_cycle_limit;
    logic [1:0] search_retry_count;
    logic strength_select_bypass;
    logic [3:0] channel_override;
    logic drift_correction_en;
    logic bitstream_capture_en;
    logic [6:0] code_kb;
    logic [6:0] data_kb;
    logic [7:0] preamble_bits;
    logic [4:0] frame_ctrl_enable_len;
    logic frame_ctrl_enable_unlim;
    logic [4:0] frame_ctrl_mode_len;
    logic frame_ctrl_mode_unlim;
    logic [5:0] ready_retime_delay;
    logic [6:0] ready_update_period;
    logic [2:0] ready_active_length;
    logic ready_active_unlim;
    logic [13:0] memory_word_count;
    logic [14:0] memory_byte_count;
    logic lbt_disable;
    logic wake_addr_manual;
    logic trx_timeout_disable;
    logic busy_link_error;
    logic parity_check_disable;
    logic wake_use_fallback;
    logic lbt_freeze;
    logic wake_timeout_en;
    logic [9:0] wake_timeout_ms;
  } wmcr_cfg_t;
endpackage : wmcr_pkg

// ==== core/wmcr_core.sv ====
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
module wmcr_core #(
  parameter int unsigned SYNTH_BASE_CYC = wmcr_pkg::SYNTH_BASE_CYC,
  parameter int unsigned SETTLE_BASE_CYC = wmcr_pkg::SETTLE_BASE_CYC,
  parameter int unsigned DWELL_BASE_CYC = wmcr_pkg::DWELL_BASE_CYC,
  parameter bit IS_BASE_STATION = 1'b1
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic RESUME_PIN,
  input wire logic RADIO_TX_REQ,
  input wire logic RADIO_RX_REQ,
  input wire logic TRANS_FAIL,
  input wire logic TRANS_OK,
  output logic FREEZE,
  output logic LINK_ERROR,
  output logic SYNTH_ON,
  output logic TRANSMIT_ON,
  output logic RECEIVE_ON,
  output logic FREQ_BLOCK_ON,
  output wmcr_pkg::wmcr_cfg_t CFG
);
  localparam int unsigned W = wmcr_pkg::CNT_W;

  typedef enum logic [1:0] {
    RT_IDLE = 2'b00,
    RT_SYNTH = 2'b01,
    RT_SETTLE = 2'b10,
    RT_ON = 2'b11
  } wmcr_rt_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [4:0] slot_of(input logic [7:0] idx);
    unique case (idx)
      wmcr_pkg::IDX_CTRL: slot_of = 5'h10;
      wmcr_pkg::IDX_SLEEP: slot_of = 5'h11;
      wmcr_pkg::IDX_RADIO: slot_of = 5'h12;
      wmcr_pkg::IDX_DWELL: slot_of = 5'h13;
      wmcr_pkg::IDX_BYPASS: slot_of = 5'h14;
      wmcr_pkg::IDX_SEARCH: slot_of = 5'h15;
      wmcr_pkg::IDX_CHAN: slot_of = 5'h16;
      wmcr_pkg::IDX_PRE: slot_of = 5'h17;
      wmcr_pkg::IDX_READY: slot_of = 5'h18;
      wmcr_pkg::IDX_MWL: slot_of = 5'h19;
      wmcr_pkg::IDX_MWH: slot_of = 5'h1A;
      wmcr_pkg::IDX_TUNE: slot_of = 5'h1B;
      default: slot_of = 5'h00; // bit 4 low marks an unmapped address
    endcase
  endfunction : slot_of

  function automatic logic [7:0] mask_of(input logic [3:0] slot);
    unique case (slot)
      4'h0: mask_of = wmcr_pkg::MASK_CTRL;
      4'h3: mask_of = wmcr_pkg::MASK_DWELL;
      4'h6: mask_of = wmcr_pkg::MASK_CHAN;
      4'h8: mask_of = wmcr_pkg::MASK_READY;
      4'hA: mask_of = wmcr_pkg::MASK_MWH;
      default: mask_of = wmcr_pkg::MASK_FULL;
    endcase
  endfunction : mask_of

  // radio timer stage counts double per code step
  function automatic logic [W-1:0] stage_cyc(input int unsigned base, input logic [1:0] code);
    stage_cyc = W'(base << code) - 21'h000001;
  endfunction : stage_cyc

  function automatic logic [1:0] fld2(input logic [7:0] r, input int unsigned lsb);
    fld2 = r[lsb +: 2];
  endfunction : fld2

  // ****************************************
  // bus slave and register file
  // ****************************************
  logic [7:0] regs_ff [wmcr_pkg::NUM_REGS];
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [4:0] dec;
  logic [3:0] slot;
  logic hit;
  logic wr_commit;
  logic [7:0] nxt_reg;
  logic resume_s1_ff;
  logic resume_s2_ff;
  logic hib_set;

  assign dec = slot_of(ADDRESS[9:2]);
  assign hit = dec[4];
  assign slot = dec[3:0];
  // one wait state on every access keeps read data registered
  assign WAITREQUEST = (READ | WRITE) & ~ack_ff;
  assign wr_commit = WRITE & ~WAITREQUEST & BYTEENABLE[0] & hit;
  assign READDATA = rdata_ff;
  // hibernate cannot be cleared by software, only by the resume pin
  assign nxt_reg = (WRITEDATA[7:0] & mask_of(slot)) |
                   ((slot == 4'h0) ? (regs_ff[0] & 8'h40) : 8'h00);
  assign hib_set = wr_commit && (slot == 4'h0) && WRITEDATA[wmcr_pkg::CTRL_HIB_BIT];

  // wait-state generator
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (READ | WRITE) & ~ack_ff;
    end
  end

  // read data captured one edge after the request; unmapped reads give zero
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 32'h00000000;
    end else if (READ && !ack_ff) begin
      rdata_ff <= hit ? {24'h000000, regs_ff[slot]} : 32'h00000000;
    end
  end

  // resume pin is asynchronous to the bus clock
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      resume_s1_ff <= 1'b0;
      resume_s2_ff <= 1'b0;
    end else begin
      resume_s1_ff <= RESUME_PIN;
      resume_s2_ff <= resume_s1_ff;
    end
  end

  // register storage; a hibernate write in the resume cycle wins
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < wmcr_pkg::NUM_REGS; i++) begin
        regs_ff[i] <= wmcr_pkg::REG_RST;
      end
    end else begin
      if (wr_commit) begin
        regs_ff[slot] <= nxt_reg;
      end
      if (resume_s2_ff && !hib_set) begin
        regs_ff[0][wmcr_pkg::CTRL_HIB_BIT] <= 1'b0;
      end
    end
  end

  assign FREEZE = regs_ff[0][wmcr_pkg::CTRL_HIB_BIT];

  // ****************************************
  // configuration decode
  // ****************************************
  wmcr_pkg::wmcr_cfg_t cfg_ff;
  wmcr_pkg::wmcr_cfg_t nxt_cfg;
  logic on;
  logic [13:0] words;

  assign on = regs_ff[0][wmcr_pkg::CTRL_ON_BIT];
  assign words = {regs_ff[10][5:0], regs_ff[9]};

  always_comb begin
    nxt_cfg = '0;
    nxt_cfg.controller_on = on;
    nxt_cfg.frame_check_enable = regs_ff[0][wmcr_pkg::CTRL_CRC_BIT];
    nxt_cfg.begin_exchange = on & regs_ff[0][wmcr_pkg::CTRL_START_BIT];
    nxt_cfg.sleep_value = regs_ff[1][5:0];
    nxt_cfg.sleep_unit = fld2(regs_ff[1], wmcr_pkg::TWO_BIT_LSB3);
    nxt_cfg.channel_wait_cyc =
      W'(DWELL_BASE_CYC << fld2(regs_ff[3], wmcr_pkg::TWO_BIT_LSB1));
    unique case (fld2(regs_ff[3], wmcr_pkg::TWO_BIT_LSB2))
      2'h0: nxt_cfg.transaction_retry_limit = 6'h02;
      2'h1: nxt_cfg.transaction_retry_limit = 6'h08;
      2'h2: nxt_cfg.transaction_retry_limit = 6'h10;
      2'h3: nxt_cfg.transaction_retry_limit = 6'h3F;
    endcase
    nxt_cfg.fallback_s = 6'h04 << fld2(regs_ff[3], wmcr_pkg::TWO_BIT_LSB3);
    nxt_cfg.controller_bypass = regs_ff[4][0];
    // 24 and 80 words seed the two doubling series of the payload limit
    unique case (regs_ff[4][wmcr_pkg::PAYLOAD_LSB +: 3])
      3'h0: nxt_cfg.payload_word_limit = 12'h018;
      3'h1: nxt_cfg.payload_word_limit = 12'h030;
      default: nxt_cfg.payload_word_limit =
        12'h050 << (regs_ff[4][wmcr_pkg::PAYLOAD_LSB +: 3] - 3'h2);
    endcase
    nxt_cfg.wait_cycle_limit = fld2(regs_ff[5], wmcr_pkg::TWO_BIT_LSB0);
    nxt_cfg.search_retry_count = fld2(regs_ff[5], wmcr_pkg::TWO_BIT_LSB1);
    nxt_cfg.strength_select_bypass = regs_ff[5][wmcr_pkg::SEARCH_STRENGTH_BIT];
    nxt_cfg.channel_override = regs_ff[6][3:0];
    nxt_cfg.drift_correction_en = regs_ff[5][wmcr_pkg::SEARCH_DRIFT_BIT];
    nxt_cfg.bitstream_capture_en = regs_ff[5][wmcr_pkg::SEARCH_STREAM_BIT];
    unique case (fld2(regs_ff[6], wmcr_pkg::TWO_BIT_LSB2))
      2'h1: {nxt_cfg.code_kb, nxt_cfg.data_kb} = {7'h10, 7'h30};
      2'h2: {nxt_cfg.code_kb, nxt_cfg.data_kb} = {7'h30, 7'h10};
      default: {nxt_cfg.code_kb, nxt_cfg.data_kb} = {7'h20, 7'h20};
    endcase
    nxt_cfg.preamble_bits =
      8'h28 * ({6'h00, fld2(regs_ff[7], wmcr_pkg::TWO_BIT_LSB0)} + 8'h01);
    nxt_cfg.frame_ctrl_enable_len = 5'h0A * {3'h0, fld2(regs_ff[7], wmcr_pkg::TWO_BIT_LSB1)};
    nxt_cfg.frame_ctrl_enable_unlim = &fld2(regs_ff[7], wmcr_pkg::TWO_BIT_LSB1);
    nxt_cfg.frame_ctrl_mode_len = 5'h0A * {3'h0, fld2(regs_ff[7], wmcr_pkg::TWO_BIT_LSB2)};
    nxt_cfg.frame_ctrl_mode_unlim = &fld2(regs_ff[7], wmcr_pkg::TWO_BIT_LSB2);
    if (nxt_cfg.frame_ctrl_enable_unlim) begin
      nxt_cfg.frame_ctrl_enable_len = 5'h00;
    end
    if (nxt_cfg.frame_ctrl_mode_unlim) begin
      nxt_cfg.frame_ctrl_mode_len = 5'h00;
    end
    // retime delay is 0 for code 0, else 10 doubled per step
    nxt_cfg.ready_retime_delay = (fld2(regs_ff[7], wmcr_pkg::TWO_BIT_LSB3) == 2'h0) ? 6'h00 :
      6'h05 << fld2(regs_ff[7], wmcr_pkg::TWO_BIT_LSB3);
    nxt_cfg.ready_update_period =
      7'h0A << fld2(regs_ff[8], wmcr_pkg::TWO_BIT_LSB1);
    nxt_cfg.ready_active_unlim = &fld2(regs_ff[8], wmcr_pkg::TWO_BIT_LSB0);
    nxt_cfg.ready_active_length = nxt_cfg.ready_active_unlim ? 3'h0 :
      3'h1 << fld2(regs_ff[8], wmcr_pkg::TWO_BIT_LSB0);
    nxt_cfg.memory_word_count = words;
    nxt_cfg.memory_byte_count = 15'(({4'h0, words} * 18'h0000B) >> 3);
    nxt_cfg.lbt_disable = regs_ff[11][0];
    nxt_cfg.wake_addr_manual = regs_ff[11][1];
    nxt_cfg.trx_timeout_disable = regs_ff[11][2];
    nxt_cfg.busy_link_error = regs_ff[11][3];
    nxt_cfg.parity_check_disable = regs_ff[11][4];
    nxt_cfg.wake_use_fallback = regs_ff[11][5];
    nxt_cfg.lbt_freeze = regs_ff[11][6];
    nxt_cfg.wake_timeout_en = ~regs_ff[11][7];
    nxt_cfg.wake_timeout_ms = IS_BASE_STATION ? wmcr_pkg::WAKE_TO_BASE_MS :
                              wmcr_pkg::WAKE_TO_TARGET_MS;
  end

  // decoded view is registered so the controller sees flop outputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign CFG = cfg_ff;

  // ****************************************
  // transaction retry counter
  // ****************************************
  logic [5:0] fail_cnt_ff;
  logic link_err_ff;
  logic give_up;

  assign give_up = on && TRANS_FAIL && !TRANS_OK &&
                   (fail_cnt_ff == cfg_ff.transaction_retry_limit);

  // held clear while the controller is off; a success restarts the count
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fail_cnt_ff <= 6'h00;
      link_err_ff <= 1'b0;
    end else begin
      link_err_ff <= give_up;
      if (!on || TRANS_OK || give_up) begin
        fail_cnt_ff <= 6'h00;
      end else if (TRANS_FAIL) begin
        fail_cnt_ff <= fail_cnt_ff + 6'h01;
      end
    end
  end

  assign LINK_ERROR = link_err_ff;

  // ****************************************
  // radio enable timer
  // ****************************************
  wmcr_rt_t rt_state_ff;
  wmcr_rt_t nxt_rt_state;
  logic [W-1:0] rt_cnt_ff;
  logic [W-1:0] nxt_rt_cnt;
  logic rt_tx_ff;
  logic nxt_rt_tx;
  logic [3:0] rf_ff;
  logic [3:0] nxt_rf;
  logic want_tx;
  logic want_any;

  // transmit has priority when both are requested
  assign want_tx = on & ~regs_ff[4][0] & RADIO_TX_REQ;
  assign want_any = on & ~regs_ff[4][0] & (RADIO_TX_REQ | RADIO_RX_REQ);

  always_comb begin
    nxt_rt_state = rt_state_ff;
    nxt_rt_cnt = rt_cnt_ff;
    nxt_rt_tx = rt_tx_ff;
    unique case (rt_state_ff)
      RT_IDLE: begin
        if (want_any) begin
          nxt_rt_state = RT_SYNTH;
          nxt_rt_tx = want_tx;
          nxt_rt_cnt = stage_cyc(SYNTH_BASE_CYC, fld2(regs_ff[2], 0));
        end
      end
      RT_SYNTH: begin
        if (!want_any) begin
          nxt_rt_state = RT_IDLE;
        end else if (rt_cnt_ff == '0) begin
          nxt_rt_state = RT_SETTLE;
          nxt_rt_tx = want_tx;
          nxt_rt_cnt = stage_cyc(SETTLE_BASE_CYC,
            fld2(regs_ff[2], want_tx ? wmcr_pkg::TWO_BIT_LSB1 : wmcr_pkg::TWO_BIT_LSB2));
        end else begin
          nxt_rt_cnt = rt_cnt_ff - 21'h000001;
        end
      end
      RT_SETTLE: begin
        if (!want_any) begin
          nxt_rt_state = RT_IDLE;
        end else if (rt_cnt_ff == '0) begin
          nxt_rt_state = RT_ON;
        end else begin
          nxt_rt_cnt = rt_cnt_ff - 21'h000001;
        end
      end
      RT_ON: begin
        if (!want_any) begin
          nxt_rt_state = RT_IDLE;
        end else if (want_tx != rt_tx_ff) begin
          // direction change keeps the synth running, pays only the turnaround
          nxt_rt_state = RT_SETTLE;
          nxt_rt_tx = want_tx;
          nxt_rt_cnt = stage_cyc(SETTLE_BASE_CYC,
            fld2(regs_ff[2], wmcr_pkg::TWO_BIT_LSB3));
        end
      end
    endcase
  end

  // enables in order {transmit, synth, receive, freq block}, as bypass bits 4..1
  always_comb begin
    if (regs_ff[4][0]) begin
      nxt_rf = regs_ff[4][4:1];
    end else begin
      nxt_rf = {(rt_state_ff == RT_ON) & rt_tx_ff, rt_state_ff != RT_IDLE,
                (rt_state_ff == RT_ON) & ~rt_tx_ff, rt_state_ff != RT_IDLE};
    end
  end

  // timer state and registered enables
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rt_state_ff <= RT_IDLE;
      rt_cnt_ff <= '0;
      rt_tx_ff <= 1'b0;
      rf_ff <= 4'h0;
    end else begin
      rt_state_ff <= nxt_rt_state;
      rt_cnt_ff <= nxt_rt_cnt;
      rt_tx_ff <= nxt_rt_tx;
      rf_ff <= nxt_rf;
    end
  end

  assign {TRANSMIT_ON, SYNTH_ON, RECEIVE_ON, FREQ_BLOCK_ON} = rf_ff;

  // ****************************************
  // assertions
  // ****************************************
  property p_crc_follows;
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_commit && slot == 4'h0) |-> ##2 (CFG.frame_check_enable == $past(WRITEDATA[4], 2));
  endproperty
  a_crc_follows: assert property (p_crc_follows) else $error("frame check bit wrong");

  property p_freeze_hold;
    @(posedge CLOCK) disable iff (!RST_N)
    (FREEZE && !resume_s2_ff) |=> FREEZE;
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("freeze left early");

  property p_freeze_resume;
    @(posedge CLOCK) disable iff (!RST_N)
    (RESUME_PIN && !WRITE) [*4] |-> !FREEZE;
  endproperty
  a_freeze_resume: assert property (p_freeze_resume) else $error("resume ignored");

  property p_synth_load;
    @(posedge CLOCK) disable iff (!RST_N)
    (rt_state_ff == RT_IDLE && want_any) |=>
      (rt_state_ff == RT_SYNTH && rt_cnt_ff == W'((SYNTH_BASE_CYC << $past(regs_ff[2][1:0])) - 1));
  endproperty
  a_synth_load: assert property (p_synth_load) else $error("sel_a count wrong");

  property p_settle_end;
    @(posedge CLOCK) disable iff (!RST_N)
    (rt_state_ff == RT_SETTLE && rt_cnt_ff == '0 && want_any) |=> ##1
      (TRANSMIT_ON == $past(rt_tx_ff) && RECEIVE_ON == !$past(rt_tx_ff));
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("enable not raised after settle");

  property p_give_up;
    @(posedge CLOCK) disable iff (!RST_N)
    give_up |=> (LINK_ERROR && fail_cnt_ff == 6'h00);
  endproperty
  a_give_up: assert property (p_give_up) else $error("retries not abandoned");

  property p_bypass;
    @(posedge CLOCK) disable iff (!RST_N)
    regs_ff[4][0] |=> ({TRANSMIT_ON, SYNTH_ON, RECEIVE_ON, FREQ_BLOCK_ON} == $past(regs_ff[4][4:1]));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass enables wrong");

  property p_payload_max;
    @(posedge CLOCK) disable iff (!RST_N)
    (regs_ff[4][7:5] == 3'h7) |=> (CFG.payload_word_limit == 12'hA00);
  endproperty
  a_payload_max: assert property (p_payload_max) else $error("payload limit wrong");

  property p_bytes;
    @(posedge CLOCK) disable iff (!RST_N)
    ##1 (CFG.memory_byte_count == 15'(({4'h0, $past(words)} * 18'h0000B) >> 3));
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte count wrong");

  property p_off_quiet;
    @(posedge CLOCK) disable iff (!RST_N)
    !on |=> (!LINK_ERROR && !CFG.begin_exchange && fail_cnt_ff == 6'h00);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity while controller off");

  property p_wake_timeout;
    @(posedge CLOCK) disable iff (!RST_N)
    regs_ff[11][7] |=> !CFG.wake_timeout_en;
  endproperty
  a_wake_timeout: assert property (p_wake_timeout) else $error("wake timeout not disabled");
endmodule : wmcr_core

// ==== tb/wmcr_core_bench.sv ====
`timescale 1ns/1ps
module wmcr_core_bench;
  // ****************************************
  // stimulus, design and checking
  // ****************************************
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [9:0] ADDRESS = 10'h000;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h00000000;
  logic RESUME_PIN = 1'b0;
  logic TX_REQ = 1'b0;
  logic RX_REQ = 1'b0;
  logic FAIL = 1'b0;
  logic OK = 1'b0;
  logic [31:0] READDATA;
  logic WAITREQUEST, FREEZE, LINK_ERROR, SYNTH_ON, TRANSMIT_ON, RECEIVE_ON, FREQ_BLOCK_ON;
  wmcr_pkg::wmcr_cfg_t CFG;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [9:0] ta [8] = '{10'h350, 10'h370, 10'h37C, 10'h3B4, 10'h3BC, 10'h354, 10'h3C4, 10'h300};
  logic [7:0] td [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hA5, 8'hFF, 8'hFF};
  logic [7:0] te [8] = '{8'h78, 8'hFC, 8'h3F, 8'h0F, 8'h3F, 8'hA5, 8'hFF, 8'h00};
  // short base counts keep the radio timer walk to a few dozen cycles
  wmcr_core #(.SYNTH_BASE_CYC(8), .SETTLE_BASE_CYC(4), .DWELL_BASE_CYC(16)) DUT (
    .CLOCK(CLOCK), .RST_N(RST_N), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .BYTEENABLE(4'hF), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .RESUME_PIN(RESUME_PIN),
    .RADIO_TX_REQ(TX_REQ), .RADIO_RX_REQ(RX_REQ), .TRANS_FAIL(FAIL), .TRANS_OK(OK),
    .FREEZE(FREEZE), .LINK_ERROR(LINK_ERROR), .SYNTH_ON(SYNTH_ON), .TRANSMIT_ON(TRANSMIT_ON),
    .RECEIVE_ON(RECEIVE_ON), .FREQ_BLOCK_ON(FREQ_BLOCK_ON), .CFG(CFG));
  // 40 MHz clock
  always #12.5 CLOCK = ~CLOCK;
  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one bus access; request held until the edge that sees waitrequest low
  task automatic acc(input logic w_en, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    logic w;
    @(posedge CLOCK);
    WRITE <= w_en;
    READ <= !w_en;
    ADDRESS <= a;
    WRITEDATA <= {24'h000000, d};
    do begin
      @(posedge CLOCK);
      w = WAITREQUEST;
      q = READDATA;
    end while (w !== 1'b0);
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask : acc
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask : rd
  // main sequence
  initial begin
    repeat (5) @(posedge CLOCK);
    RST_N <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ta[i], 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ta[i], td[i]);
      rd(ta[i], te[i]);
    end
    repeat (2) @(posedge CLOCK);
    #1;
    chk(CFG.transaction_retry_limit, 32'h0000003F);
    chk(CFG.fallback_s, 32'h00000020);
    chk(CFG.channel_wait_cyc, 32'h00000080);
    chk(CFG.memory_byte_count, 32'h000056A0);
    chk({CFG.sleep_unit, CFG.sleep_value}, 32'h000000A5);
    chk({CFG.wake_timeout_en, CFG.lbt_disable, CFG.begin_exchange}, 32'h00000003);
    chk({FREEZE, CFG.frame_check_enable}, 32'h00000003);
    // a control write with bit 6 clear must not end hibernation; only the resume pin does
    wr(10'h350, 8'h08);
    wr(10'h370, 8'h00);
    repeat (2) @(posedge CLOCK);
    #1;
    chk({FREEZE, CFG.begin_exchange}, 32'h00000002);
    @(posedge CLOCK) RESUME_PIN <= 1'b1;
    repeat (5) @(posedge CLOCK);
    #1;
    chk(FREEZE, 32'h00000000);
    // three failures in a row with limit two give one error pulse
    @(posedge CLOCK) RESUME_PIN <= 1'b0;
    OK <= 1'b1;
    @(posedge CLOCK) OK <= 1'b0;
    FAIL <= 1'b1;
    repeat (2) @(posedge CLOCK);
    #1;
    chk(LINK_ERROR, 32'h00000000);
    @(posedge CLOCK) FAIL <= 1'b0;
    #1;
    chk(LINK_ERROR, 32'h00000001);
    @(posedge CLOCK);
    #1;
    chk(LINK_ERROR, 32'h00000000);
    // transmit start: synth and block stay on, receive stays off
    @(posedge CLOCK) TX_REQ <= 1'b1;
    for (int k = 0; k < 100 && TRANSMIT_ON !== 1'b1; k++) @(posedge CLOCK);
    #1;
    chk({SYNTH_ON, FREQ_BLOCK_ON, RECEIVE_ON, TRANSMIT_ON}, 32'h0000000D);
    // turn to receive: synth stays up, only the turnaround is paid
    @(posedge CLOCK) TX_REQ <= 1'b0;
    RX_REQ <= 1'b1;
    for (int k = 0; k < 100 && RECEIVE_ON !== 1'b1; k++) @(posedge CLOCK);
    #1;
    chk({SYNTH_ON, FREQ_BLOCK_ON, RECEIVE_ON, TRANSMIT_ON}, 32'h0000000E);
    @(posedge CLOCK) RX_REQ <= 1'b0;
    wr(10'h374, 8'hF5);
    repeat (3) @(posedge CLOCK);
    #1;
    chk({SYNTH_ON, FREQ_BLOCK_ON, RECEIVE_ON, TRANSMIT_ON}, 32'h00000003);
    chk(CFG.payload_word_limit, 32'h00000A00);
    test_done();
  end
endmodule : wmcr_core_bench
